// ==== owr_watchdog.v ====
/*
 * Operating watchdog reset unit: watchdog counter, write-once system
 * configuration, stop instruction check, reset pin drive and sensing,
 * sticky event status with interrupt, AXI4-Lite register slave.
 * Assumes all inputs are synchronous to clock_i and that the CPU core
 * reports each executed stop instruction as a one-cycle pulse.
 */
// What this block does
// - write to clear location restarts watchdog counter
// - counter expiry generates a system reset
// - watchdog enabled and counting out of reset
// - config disable bit, config writable once per reset
// - clear location reads vector byte, writes clear
// - stop mode entered only when stop enabled
// - disabled stop is illegal, short reset pulse
// - internal resets driven onto bidirectional reset pin
`timescale 1ns/1ns
`include "owr_map.vh"

module owr_watchdog #(
  parameter [`OWR_CNT_W-1:0] WDT_TIMEOUT = `OWR_TIMEOUT_DEF,
  parameter [7:0] RESET_VEC_LO = 8'h00
) (
  input wire clock_i,
  input wire rstn_i,
  input wire [`OWR_AW-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`OWR_AW-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire stop_exec_i,
  input wire wake_i,
  input wire rst_pin_i,
  output reg rst_pin_o,
  output reg rst_pin_oe_o,
  output reg sys_reset_o,
  output reg stop_mode_o,
  output reg irq_o
);

  reg aw_got_reg;
  reg w_got_reg;
  reg [`OWR_AW-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [1:0] cfg_reg;
  reg cfg_locked_reg;
  reg [`OWR_ST_W-1:0] status_reg;
  reg [`OWR_ST_W-1:0] irq_en_reg;
  reg [`OWR_CNT_W-1:0] wd_cnt_reg;
  reg [3:0] rst_cnt_reg;
  reg ext_seen_reg;

  wire do_write;
  wire wr_ok;
  wire wr_cfg;
  wire wr_clr;
  wire wr_en;
  wire wr_iclr;
  wire rst_active;
  wire ext_rst;
  wire soft_rst;
  wire wd_expire;
  wire ill_stop;
  wire rst_trig;
  wire [`OWR_ST_W-1:0] st_set;
  wire [`OWR_ST_W-1:0] st_clr;
  wire [`OWR_ST_W-1:0] status_next;
  reg [31:0] rd_data;
  reg rd_ok;

  // write commits once both address and data are held
  assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid_o;
  assign wr_cfg = do_write && (aw_addr_reg == `OWR_ADDR_CFG);
  assign wr_clr = do_write && (aw_addr_reg == `OWR_ADDR_CLR);
  assign wr_en = do_write && (aw_addr_reg == `OWR_ADDR_IRQ_EN);
  assign wr_iclr = do_write && (aw_addr_reg == `OWR_ADDR_IRQ_CLR);
  assign wr_ok = wr_cfg || wr_clr || wr_en || wr_iclr;

  assign rst_active = (rst_cnt_reg != 4'h0);
  // pin low while we are not driving it means an outside reset
  assign ext_rst = !rst_pin_i && !rst_pin_oe_o;
  // internal and outside resets both return the core state to defaults
  assign soft_rst = rst_active || ext_rst;

  assign wd_expire = !cfg_reg[`OWR_CFG_WD_DIS] && !soft_rst &&
                     (wd_cnt_reg == WDT_TIMEOUT) && !wr_clr;
  assign ill_stop = stop_exec_i && !soft_rst &&
                    !cfg_reg[`OWR_CFG_STOP_EN];
  assign rst_trig = wd_expire || ill_stop;

  assign st_set = {ext_rst && !ext_seen_reg, ill_stop, wd_expire};
  assign st_clr = wr_iclr ? w_data_reg[`OWR_ST_W-1:0] : {`OWR_ST_W{1'b0}};
  // a new event wins over a clear in the same cycle
  assign status_next = (status_reg & ~st_clr) | st_set;

  // axi write channels
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= {`OWR_AW{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `OWR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      s_axi_awready_o <= !aw_got_reg && !(s_axi_awvalid_i &&
                         s_axi_awready_o) && !s_axi_bvalid_o;
      s_axi_wready_o <= !w_got_reg && !(s_axi_wvalid_i &&
                        s_axi_wready_o) && !s_axi_bvalid_o;
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? `OWR_RESP_OKAY : `OWR_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
    end
  end

  // read mux
  always @* begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr_i)
      `OWR_ADDR_CFG: begin
        rd_data[1:0] = cfg_reg;
        rd_data[`OWR_CFG_LOCKED] = cfg_locked_reg;
      end
      `OWR_ADDR_STATUS: begin
        rd_data[`OWR_ST_W-1:0] = status_reg;
      end
      `OWR_ADDR_IRQ_EN: begin
        rd_data[`OWR_ST_W-1:0] = irq_en_reg;
      end
      `OWR_ADDR_IRQ_CLR: begin
        rd_data = 32'h00000000;
      end
      `OWR_ADDR_COUNT: begin
        rd_data[`OWR_CNT_W-1:0] = wd_cnt_reg;
      end
      `OWR_ADDR_STATE: begin
        rd_data[`OWR_STATE_STOP] = stop_mode_o;
        rd_data[`OWR_STATE_RST] = rst_active;
      end
      `OWR_ADDR_CLR: begin
        rd_data[7:0] = RESET_VEC_LO;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // axi read channel: one cycle from address to data
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `OWR_RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o &&
                         !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_data;
        s_axi_rresp_o <= rd_ok ? `OWR_RESP_OKAY : `OWR_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // write-once configuration; a system reset reopens it
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg <= `OWR_CFG_RESET;
      cfg_locked_reg <= 1'b0;
    end else if (soft_rst) begin
      cfg_reg <= `OWR_CFG_RESET;
      cfg_locked_reg <= 1'b0;
    end else if (wr_cfg && !cfg_locked_reg) begin
      // only the first write after reset lands, later ones are dropped
      if (w_strb_reg[0]) begin
        cfg_reg <= w_data_reg[1:0];
      end
      cfg_locked_reg <= 1'b1;
    end
  end

  // watchdog counter
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wd_cnt_reg <= {`OWR_CNT_W{1'b0}};
    end else if (soft_rst || wr_clr) begin
      // any value written clears; the vector byte stays read-only
      wd_cnt_reg <= {`OWR_CNT_W{1'b0}};
    end else if (wd_expire) begin
      wd_cnt_reg <= {`OWR_CNT_W{1'b0}};
    end else if (!cfg_reg[`OWR_CFG_WD_DIS]) begin
      wd_cnt_reg <= wd_cnt_reg + {{(`OWR_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // reset pulse and pin drive
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_cnt_reg <= 4'h0;
      sys_reset_o <= 1'b0;
      rst_pin_o <= 1'b0;
      rst_pin_oe_o <= 1'b0;
    end else begin
      if (rst_trig) begin
        rst_cnt_reg <= `OWR_RST_PULSE;
      end else if (rst_active) begin
        rst_cnt_reg <= rst_cnt_reg - 4'h1;
      end
      // the pin is only ever pulled low, never driven high
      rst_pin_o <= 1'b0;
      rst_pin_oe_o <= rst_trig || (rst_cnt_reg > 4'h1);
      sys_reset_o <= rst_trig || (rst_cnt_reg > 4'h1) || ext_rst;
    end
  end

  // stop mode
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_mode_o <= 1'b0;
    end else if (soft_rst || wake_i) begin
      stop_mode_o <= 1'b0;
    end else if (stop_exec_i && cfg_reg[`OWR_CFG_STOP_EN]) begin
      stop_mode_o <= 1'b1;
    end
  end

  // sticky events and interrupt; status survives the soft reset so
  // software can tell why it restarted
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_reg <= {`OWR_ST_W{1'b0}};
      irq_en_reg <= {`OWR_ST_W{1'b0}};
      ext_seen_reg <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      status_reg <= status_next;
      ext_seen_reg <= ext_rst;
      if (wr_en && w_strb_reg[0]) begin
        irq_en_reg <= w_data_reg[`OWR_ST_W-1:0];
      end
      irq_o <= |(status_next & irq_en_reg);
    end
  end

endmodule

// ==== owr_map.vh ====
/*
 * Register map, field positions, reset values and timing counts of the
 * operating watchdog reset unit.
 * Assumes a 32-bit AXI4-Lite bus with 18-bit byte addresses.
 */
`ifndef OWR_MAP_VH
`define OWR_MAP_VH

`define OWR_AW 18
`define OWR_ADDR_CFG 18'h00000
`define OWR_ADDR_STATUS 18'h00004
`define OWR_ADDR_IRQ_EN 18'h00008
`define OWR_ADDR_IRQ_CLR 18'h0000c
`define OWR_ADDR_COUNT 18'h00010
`define OWR_ADDR_STATE 18'h00014
// clear location index; byte address is four times the index
`define OWR_IDX_CLR 16'hffff
`define OWR_ADDR_CLR ({`OWR_IDX_CLR, 2'b00})

`define OWR_CFG_WD_DIS 0
`define OWR_CFG_STOP_EN 1
`define OWR_CFG_LOCKED 8
`define OWR_CFG_RESET 2'h0

`define OWR_ST_WDOG 0
`define OWR_ST_ILLSTOP 1
`define OWR_ST_EXTRST 2
`define OWR_ST_W 3

`define OWR_STATE_STOP 0
`define OWR_STATE_RST 1

`define OWR_CNT_W 18
`define OWR_TIMEOUT_DEF 18'h3ffff
`define OWR_RST_PULSE 4'h4

`define OWR_RESP_OKAY 2'h0
`define OWR_RESP_SLVERR 2'h2

`endif

// ==== owr_props.sv ====
/* owr_props: concurrent checks on the watchdog unit's ports.
   assumes binding to owr_watchdog with the same timeout. */
`timescale 1ns/1ns
module owr_props #(parameter [17:0] WDT_TIMEOUT = 18'h3ffff) (
  input wire clock_i,
  input wire rstn_i,
  input wire [17:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire stop_exec_i,
  input wire wake_i,
  input wire rst_pin_i,
  input wire rst_pin_oe_o,
  input wire sys_reset_o,
  input wire stop_mode_o
);
  int q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // cycles since the last clear-location address was taken; the counter
  // clears no earlier, so expiry needs at least the timeout here
  always @(posedge clock_i or negedge rstn_i)
    if (!rstn_i || sys_reset_o) q <= 0;
    else if (s_axi_awvalid_i && s_axi_awready_o &&
             s_axi_awaddr_i == 18'h3fffc) q <= 0;
    else q <= q + 1;
  pulse_len_a: assert property ($rose(rst_pin_oe_o) |->
    rst_pin_oe_o [*4] ##1 !rst_pin_oe_o) else $error("pulse length");
  pin_drive_a: assert property (rst_pin_oe_o |-> sys_reset_o)
    else $error("pin driven without reset");
  early_expiry_a: assert property ($rose(rst_pin_oe_o) &&
    !$past(stop_exec_i) && !$past(stop_exec_i, 2)
    |-> q >= int'(WDT_TIMEOUT) - 4) else $error("early expiry");
  stop_enter_a: assert property (stop_exec_i && !sys_reset_o |=>
    stop_mode_o || rst_pin_oe_o) else $error("stop ignored");
  stop_hold_a: assert property (stop_mode_o && !wake_i &&
    rst_pin_i |=> stop_mode_o || sys_reset_o) else $error("stop lost");
  ext_reset_a: assert property (!rst_pin_i && !rst_pin_oe_o
    |=> sys_reset_o) else $error("outside reset missed");
  rd_answer_a: assert property (s_axi_arvalid_i &&
    s_axi_arready_o |=> s_axi_rvalid_o) else $error("no read answer");
  wr_done_a: assert property (s_axi_bvalid_o &&
    s_axi_bready_i |=> !s_axi_bvalid_o) else $error("bvalid stuck");
endmodule
bind owr_watchdog owr_props #(.WDT_TIMEOUT(WDT_TIMEOUT)) u_props (
  .clock_i(clock_i), .rstn_i(rstn_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .stop_exec_i(stop_exec_i), .wake_i(wake_i), .rst_pin_i(rst_pin_i),
  .rst_pin_oe_o(rst_pin_oe_o), .sys_reset_o(sys_reset_o),
  .stop_mode_o(stop_mode_o));

// ==== owr_dbg_ctl.sv ====
/* owr_dbg_ctl: outside debug controller on the reset pin.
   assumes a pull-up on the pin and a clock shared with the unit. */
`timescale 1ns/1ns
module owr_dbg_ctl (
  input wire clock_i,
  input wire dut_oe_i,
  input wire dut_o_i,
  input wire hold_low_i,
  output wire pin_o,
  output int resets_o = 0
);
  logic last = 1'b1;
  // pull-up wins whenever nobody drives the line
  assign pin_o = dut_oe_i ? dut_o_i : !hold_low_i;
  always @(posedge clock_i) begin
    last <= pin_o;
    if (last && !pin_o)
      resets_o <= resets_o + 1; // count each falling edge sensed on the line
  end
endmodule

// ==== owr_watchdog_tb.sv ====
/* owr_watchdog_tb: self-checking bench for the watchdog unit.
   assumes owr_map.vh, owr_dbg_ctl and owr_props compiled before. */
`timescale 1ns/1ns
`include "owr_map.vh"
module owr_watchdog_tb;
  localparam [17:0] TMO = 18'h0003c;
  localparam [7:0] VEC = 8'h5a;
  localparam logic [51:0] ROWS [7] = '{{`OWR_ADDR_CFG, 34'h0},
    {`OWR_ADDR_STATUS, 34'h0}, {`OWR_ADDR_IRQ_EN, 34'h0},
    {`OWR_ADDR_IRQ_CLR, 34'h0}, {`OWR_ADDR_STATE, 34'h0},
    {`OWR_ADDR_CLR, 24'h0, VEC, 2'h0}, {18'h00018, 32'h0, 2'h2}};
  logic clock_i = 0, rstn_i = 0, awv = 0, wv = 0, bre = 0, arv = 0;
  logic rre = 0, stop = 0, wake = 0, hold = 0;
  logic awr, wr_, bv, arr, rv, po, oe, sr, sm, irq, pin;
  logic [17:0] aw = 0, ar = 0;
  logic [31:0] wd = 0, rdata, d;
  logic [1:0] bresp, rresp, r;
  int errors = 0, total_checks = 0, cyc = 0, k, n0, rs;
  owr_watchdog #(.WDT_TIMEOUT(TMO), .RESET_VEC_LO(VEC)) dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .s_axi_awaddr_i(aw),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .stop_exec_i(stop), .wake_i(wake),
    .rst_pin_i(pin), .rst_pin_o(po), .rst_pin_oe_o(oe),
    .sys_reset_o(sr), .stop_mode_o(sm), .irq_o(irq));
  owr_dbg_ctl dbg (.clock_i(clock_i), .dut_oe_i(oe), .dut_o_i(po),
    .hold_low_i(hold), .pin_o(pin), .resets_o(rs));
  initial forever #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input [17:0] a, input [31:0] v);
    @(posedge clock_i);
    aw <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(posedge clock_i);
      if (awv && awr) awv <= 0;
      if (wv && wr_) wv <= 0;
    end while (bv !== 1'b1);
    bre <= 0;
  endtask
  task rd(input [17:0] a);
    @(posedge clock_i);
    ar <= a;
    arv <= 1;
    rre <= 1;
    do begin
      @(posedge clock_i);
      if (arv && arr) arv <= 0;
    end while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    rre <= 0;
  endtask
  task wrst(input int lim);
    k = 0;
    while (sr !== 1'b1 && k < lim) begin
      @(posedge clock_i);
      k++;
    end
  endtask
  task pulse_stop;
    @(posedge clock_i);
    stop <= 1;
    @(posedge clock_i);
    stop <= 0;
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1;
    foreach (ROWS[i]) begin
      rd(ROWS[i][51:34]);
      chk("resp", ROWS[i][1:0], r);
      if (ROWS[i][1:0] == 2'h0) chk("data", ROWS[i][33:2], d);
    end
    $display("done reset values");
    n0 = rs;
    repeat (5) begin
      rd(`OWR_ADDR_CLR);
      wr(`OWR_ADDR_CLR, d);
      repeat (40) @(posedge clock_i);
    end
    chk("resets", n0, rs);
    rd(`OWR_ADDR_CLR);
    chk("vector", VEC, d);
    $display("done service");
    wr(`OWR_ADDR_IRQ_EN, 32'h7);
    wrst(100);
    chk("expiry", 1, sr);
    chk("pin low", 0, pin);
    chk("pin drive", 0, po);
    repeat (8) @(posedge clock_i);
    chk("irq", 1, irq);
    rd(`OWR_ADDR_STATUS);
    chk("status", 1, d);
    chk("seen", n0 + 1, rs);
    wr(`OWR_ADDR_IRQ_CLR, 32'h7);
    repeat (2) @(posedge clock_i);
    chk("irq off", 0, irq);
    $display("done expiry");
    pulse_stop;
    wrst(10);
    chk("illegal", 1, sr);
    chk("no stop", 0, sm);
    repeat (6) @(posedge clock_i);
    rd(`OWR_ADDR_STATUS);
    chk("status", 2, d);
    wr(`OWR_ADDR_CFG, 32'h2);
    wr(`OWR_ADDR_CFG, 32'h1);
    rd(`OWR_ADDR_CFG);
    chk("cfg once", 32'h102, d);
    pulse_stop;
    @(posedge clock_i);
    chk("stop", 1, sm);
    wake <= 1;
    @(posedge clock_i);
    wake <= 0;
    @(posedge clock_i);
    chk("wake", 0, sm);
    $display("done stop");
    rstn_i <= 0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1;
    n0 = rs;
    wr(`OWR_ADDR_CFG, 32'h1);
    repeat (200) @(posedge clock_i);
    chk("disabled", n0, rs);
    @(posedge clock_i);
    hold <= 1;
    repeat (2) @(posedge clock_i);
    hold <= 0;
    chk("outside", 1, sr);
    repeat (6) @(posedge clock_i);
    rd(`OWR_ADDR_STATUS);
    chk("status", 4, d);
    rd(`OWR_ADDR_CFG);
    chk("cfg", 0, d);
    chk("seen", n0 + 1, rs);
    $display("done disable");
    wrap_up;
  end
endmodule
